// [design/short_opcode_class_decoder.sv]
`timescale 1ns/100ps
// Functional notes
// RULE1: decode three cache maintenance ranges
// RULE2: 0x09C0-09FF unsigned pointer less-than compare
// RULE3: 0x0A00-0A3F unsigned data less-or-equal compare
// RULE4: 0x0A40-0A7F unsigned pointer less-or-equal compare
// RULE5: 0x0A80 accumulator equality compare
// RULE6: 0x0B80 accumulator less-or-equal, 0x0B00 less-than
// RULE7: immediate equality compares, data and pointer
// RULE8: 0x0C80-0CBF data signed less-than immediate
// RULE9: 0x0CC0-0CFF pointer signed less-than immediate
// RULE10: signed less-or-equal immediate compares
// RULE11: unsigned less-than immediate compares
// RULE12: unsigned less-or-equal immediate compares
// RULE13: 0x1000-13FF jump when flag clear
// RULE14: 0x1C00-1FFF jump when flag set, hinted
// RULE15: 0x3000-3FFF register moves with group subfields
// RULE16: 0x4000-403F arithmetic right shift by register
// RULE17: logical right and left shifts by register
// RULE18: 0x40C0-40FF 32-bit multiply into first operand
// RULE19: 0x4100-413F add then shift left one
// RULE20: 0x4140-417F add then shift left two
// RULE21: 0x4200-423F divide quotient step
// RULE22: middle jump ranges: clear+hint, set without hint
// RULE23: fixed control codes and low-index register forms
// RULE24: anything unrecognised flagged undefined
module short_opcode_class_decoder
  import opcode_class_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic condition_flag,
  output logic decoded_valid,
  output op_class_t op_class,
  output control_op_t control_op,
  output cache_op_t cache_op,
  output alu_op_t alu_op,
  output relation_t compare_relation,
  output operand_t compare_operand,
  output logic unsigned_compare_option,
  output logic compare_uses_imm,
  output logic [31:0] compare_imm,
  output logic condition_flag_write,
  output logic jump_on_flag_set,
  output logic predicted_taken_hint,
  output logic jump_taken,
  output logic [12:0] jump_offset,
  output logic [2:0] reg_dst,
  output logic [2:0] reg_src,
  output logic [2:0] move_dst_group,
  output logic [2:0] move_src_group,
  output logic undefined_insn
);

  typedef struct packed {
    logic valid;
    op_class_t cls;
    control_op_t ctl;
    cache_op_t cache;
    alu_op_t alu;
    relation_t rel;
    operand_t opnd;
    logic unsgn;
    logic use_imm;
    logic [31:0] imm;
    logic flag_wr;
    logic on_set;
    logic hint;
    logic taken;
    logic [12:0] offset;
    logic [2:0] dst;
    logic [2:0] src;
    logic [2:0] dgrp;
    logic [2:0] sgrp;
    logic undef;
  } state_t;

  state_t state;
  state_t next_state;

  logic cmp_hit;
  relation_t cmp_rel;
  operand_t cmp_opnd;
  logic cmp_unsigned;
  logic cmp_imm_used;
  logic [31:0] cmp_imm_value;

  compare_class_decoder u_compare (
    .insn(insn_word),
    .is_compare(cmp_hit),
    .relation(cmp_rel),
    .operand(cmp_opnd),
    .unsigned_compare_option(cmp_unsigned),
    .uses_imm(cmp_imm_used),
    .imm_value(cmp_imm_value)
  );

  always_comb
  begin
    next_state = '0;
    next_state.valid = insn_valid;
    next_state.cls = op_undefined;
    // operand fields are passed through raw; consumers ignore them per class
    next_state.dst = insn_word[5:3];
    next_state.src = insn_word[2:0];

    if (insn_word == NOP_CODE)
    begin
      next_state.cls = op_nop; // see RULE23
    end
    else if (insn_word >= SUB_RETURN_CODE && insn_word <= EMU_RETURN_CODE)
    begin
      next_state.cls = op_return; // see RULE23
      case (insn_word[2:0])
        3'h0: next_state.ctl = ctl_subroutine_return;
        3'h1: next_state.ctl = ctl_interrupt_return;
        3'h2: next_state.ctl = ctl_exception_return;
        3'h3: next_state.ctl = ctl_nmi_return;
        default: next_state.ctl = ctl_emulation_return;
      endcase
    end
    else if (insn_word == IDLE_CODE || insn_word == CORE_SYNC_CODE
             || insn_word == SYSTEM_SYNC_CODE || insn_word == EMU_EXCEPTION_CODE
             || insn_word == ABORT_CODE)
    begin
      next_state.cls = op_control; // see RULE23
      case (insn_word)
        IDLE_CODE: next_state.ctl = ctl_idle;
        CORE_SYNC_CODE: next_state.ctl = ctl_core_sync;
        SYSTEM_SYNC_CODE: next_state.ctl = ctl_system_sync;
        EMU_EXCEPTION_CODE: next_state.ctl = ctl_emulation_exception;
        default: next_state.ctl = ctl_abort;
      endcase
    end
    else if (in_range(insn_word, IRQ_DISABLE_LO, IRQ_DISABLE_HI)
             || in_range(insn_word, IRQ_ENABLE_LO, IRQ_ENABLE_HI))
    begin
      // the saved mask goes to or comes from the data register in bits 2:0
      next_state.cls = op_irq_mask; // see RULE23
      next_state.ctl = in_range(insn_word, IRQ_DISABLE_LO, IRQ_DISABLE_HI)
                       ? ctl_interrupt_disable : ctl_interrupt_enable;
      next_state.dst = insn_word[2:0];
    end
    else if (in_range(insn_word, INDIRECT_JUMP_LO, INDIRECT_JUMP_HI))
    begin
      next_state.cls = op_indirect_jump; // see RULE23
      next_state.taken = 1'b1;
    end
    else if (in_range(insn_word, DCACHE_INV_LO, ICACHE_FLUSH_HI))
    begin
      // pointer register in bits 2:0 is post-incremented by the line size
      next_state.cls = op_cache; // see RULE1
      if (in_range(insn_word, DCACHE_INV_LO, DCACHE_INV_HI))
        next_state.cache = cache_dline_invalidate; // see RULE1
      else if (in_range(insn_word, DCACHE_FLUSH_LO, DCACHE_FLUSH_HI))
        next_state.cache = cache_dflush; // see RULE1
      else
        next_state.cache = cache_icache_line_flush; // see RULE1
    end
    else if (cmp_hit)
    begin
      // register and immediate compares share one slot layout in the helper
      next_state.cls = op_compare; // see RULE2
      next_state.flag_wr = 1'b1; // see RULE3
      next_state.rel = cmp_rel; // see RULE4
      next_state.opnd = cmp_opnd; // see RULE5
      next_state.unsgn = cmp_unsigned; // see RULE11
      next_state.use_imm = cmp_imm_used; // see RULE7
      next_state.imm = cmp_imm_value; // see RULE8
      // accumulator forms carry no register fields, so clear them for them
      if (cmp_opnd == opnd_accum)
      begin
        next_state.dst = 3'h0; // see RULE6
        next_state.src = 3'h0;
      end
      // immediate forms: bits 5:3 are the constant, register sits in 2:0
      if (cmp_imm_used)
      begin
        next_state.dst = insn_word[2:0]; // see RULE9
        next_state.src = 3'h0; // see RULE10
      end
      else if (cmp_opnd != opnd_accum)
      begin
        next_state.dst = insn_word[2:0]; // see RULE12
        next_state.src = insn_word[5:3];
      end
    end
    else if (in_range(insn_word, COND_JUMP_LO, COND_JUMP_HI))
    begin
      // one printed bound pair per middle quarter disagrees; bits 11:10 decide
      next_state.cls = op_cond_jump; // see RULE13
      next_state.on_set = insn_word[FLAG_SET_BIT]; // see RULE14
      next_state.hint = insn_word[HINT_BIT]; // see RULE22
      next_state.taken = (condition_flag == insn_word[FLAG_SET_BIT]); // see RULE13
      next_state.offset = {{2{insn_word[9]}}, insn_word[9:0], 1'b0}; // see RULE14
    end
    else if (in_range(insn_word, SHORT_JUMP_LO, SHORT_JUMP_HI))
    begin
      next_state.cls = op_short_jump;
      next_state.taken = 1'b1;
      next_state.offset = {insn_word[11:0], 1'b0};
    end
    else if (in_range(insn_word, REG_MOVE_LO, REG_MOVE_HI))
    begin
      next_state.cls = op_reg_move; // see RULE15
      next_state.dgrp = insn_word[11:9]; // see RULE15
      next_state.sgrp = insn_word[8:6]; // see RULE15
    end
    else if (in_range(insn_word, ASHR_LO, ADD_SHL2_HI)
             || in_range(insn_word, DIVIDE_QUOTIENT_STEP_LO, DIVIDE_QUOTIENT_STEP_HI))
    begin
      // result register in bits 2:0, second operand or count in bits 5:3
      next_state.cls = op_alu;
      next_state.dst = insn_word[2:0];
      next_state.src = insn_word[5:3];
      if (in_range(insn_word, ASHR_LO, ASHR_HI))
        next_state.alu = alu_ashr; // see RULE16
      else if (in_range(insn_word, LSHR_LO, LSHR_HI))
        next_state.alu = alu_lshr; // see RULE17
      else if (in_range(insn_word, LSHL_LO, LSHL_HI))
        next_state.alu = alu_lshl; // see RULE17
      else if (in_range(insn_word, MUL_LO, MUL_HI))
        next_state.alu = alu_mul; // see RULE18
      else if (in_range(insn_word, ADD_SHL1_LO, ADD_SHL1_HI))
        next_state.alu = alu_add_shl1; // see RULE19
      else if (in_range(insn_word, ADD_SHL2_LO, ADD_SHL2_HI))
        next_state.alu = alu_add_shl2; // see RULE20
      else
        next_state.alu = alu_divide_step; // see RULE21
    end

    // a hole in the covered space must reach the exception logic
    if (next_state.cls == op_undefined)
    begin
      next_state.undef = insn_valid; // see RULE24
      next_state.dst = 3'h0;
      next_state.src = 3'h0;
    end

    // a bubble must not look like an instruction downstream
    if (!insn_valid)
    begin
      next_state = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= '0;
    else
      state <= next_state;
  end

  always_comb
  begin
    decoded_valid = state.valid;
    op_class = state.cls;
    control_op = state.ctl;
    cache_op = state.cache;
    alu_op = state.alu;
    compare_relation = state.rel;
    compare_operand = state.opnd;
    unsigned_compare_option = state.unsgn;
    compare_uses_imm = state.use_imm;
    compare_imm = state.imm;
    condition_flag_write = state.flag_wr;
    jump_on_flag_set = state.on_set;
    predicted_taken_hint = state.hint;
    jump_taken = state.taken;
    jump_offset = state.offset;
    reg_dst = state.dst;
    reg_src = state.src;
    move_dst_group = state.dgrp;
    move_src_group = state.sgrp;
    undefined_insn = state.undef;
  end

endmodule

// [design/opcode_class_pkg.sv]
package opcode_class_pkg;

  localparam logic [15:0] NOP_CODE = 16'h0000;
  localparam logic [15:0] SUB_RETURN_CODE = 16'h0010;
  localparam logic [15:0] IRQ_RETURN_CODE = 16'h0011;
  localparam logic [15:0] EXC_RETURN_CODE = 16'h0012;
  localparam logic [15:0] NMI_RETURN_CODE = 16'h0013;
  localparam logic [15:0] EMU_RETURN_CODE = 16'h0014;
  localparam logic [15:0] IDLE_CODE = 16'h0020;
  localparam logic [15:0] CORE_SYNC_CODE = 16'h0023;
  localparam logic [15:0] SYSTEM_SYNC_CODE = 16'h0024;
  localparam logic [15:0] EMU_EXCEPTION_CODE = 16'h0025;
  localparam logic [15:0] ABORT_CODE = 16'h002f;
  localparam logic [15:0] IRQ_DISABLE_LO = 16'h0030;
  localparam logic [15:0] IRQ_DISABLE_HI = 16'h0037;
  localparam logic [15:0] IRQ_ENABLE_LO = 16'h0040;
  localparam logic [15:0] IRQ_ENABLE_HI = 16'h0047;
  localparam logic [15:0] INDIRECT_JUMP_LO = 16'h0050;
  localparam logic [15:0] INDIRECT_JUMP_HI = 16'h0057;

  localparam logic [15:0] DCACHE_INV_LO = 16'h0268;
  localparam logic [15:0] DCACHE_INV_HI = 16'h026f;
  localparam logic [15:0] DCACHE_FLUSH_LO = 16'h0270;
  localparam logic [15:0] DCACHE_FLUSH_HI = 16'h0277;
  localparam logic [15:0] ICACHE_FLUSH_LO = 16'h0278;
  localparam logic [15:0] ICACHE_FLUSH_HI = 16'h027f;

  // register compares: ten 64-code slots, slot index in bits 9:6
  localparam logic [15:0] REG_CMP_LO = 16'h0800;
  localparam logic [15:0] REG_CMP_HI = 16'h0a7f;
  localparam logic [15:0] ACC_EQ_CODE = 16'h0a80;
  localparam logic [15:0] ACC_LT_CODE = 16'h0b00;
  localparam logic [15:0] ACC_LE_CODE = 16'h0b80;
  // immediate compares: same slot layout starting here
  localparam logic [15:0] IMM_CMP_LO = 16'h0c00;
  localparam logic [15:0] IMM_CMP_HI = 16'h0e7f;
  localparam logic [3:0] SLOT_EQ = 4'h0;
  localparam logic [3:0] SLOT_LT = 4'h2;
  localparam logic [3:0] SLOT_LE = 4'h4;
  localparam logic [3:0] SLOT_LTU = 4'h6;
  localparam logic [3:0] SLOT_LEU = 4'h8;

  localparam logic [15:0] COND_JUMP_LO = 16'h1000;
  localparam logic [15:0] COND_JUMP_HI = 16'h1fff;
  localparam int FLAG_SET_BIT = 11;
  localparam int HINT_BIT = 10;
  localparam logic [15:0] SHORT_JUMP_LO = 16'h2000;
  localparam logic [15:0] SHORT_JUMP_HI = 16'h2fff;
  localparam logic [15:0] REG_MOVE_LO = 16'h3000;
  localparam logic [15:0] REG_MOVE_HI = 16'h3fff;

  localparam logic [15:0] ASHR_LO = 16'h4000;
  localparam logic [15:0] ASHR_HI = 16'h403f;
  localparam logic [15:0] LSHR_LO = 16'h4040;
  localparam logic [15:0] LSHR_HI = 16'h407f;
  localparam logic [15:0] LSHL_LO = 16'h4080;
  localparam logic [15:0] LSHL_HI = 16'h40bf;
  localparam logic [15:0] MUL_LO = 16'h40c0;
  localparam logic [15:0] MUL_HI = 16'h40ff;
  localparam logic [15:0] ADD_SHL1_LO = 16'h4100;
  localparam logic [15:0] ADD_SHL1_HI = 16'h413f;
  localparam logic [15:0] ADD_SHL2_LO = 16'h4140;
  localparam logic [15:0] ADD_SHL2_HI = 16'h417f;
  localparam logic [15:0] DIVIDE_QUOTIENT_STEP_LO = 16'h4200;
  localparam logic [15:0] DIVIDE_QUOTIENT_STEP_HI = 16'h423f;

  typedef enum logic [3:0] {
    op_undefined, op_nop, op_control, op_return, op_irq_mask, op_indirect_jump,
    op_cache, op_compare, op_cond_jump, op_short_jump, op_reg_move, op_alu
  } op_class_t;

  typedef enum logic [3:0] {
    ctl_none, ctl_idle, ctl_core_sync, ctl_system_sync, ctl_emulation_exception,
    ctl_abort, ctl_subroutine_return, ctl_interrupt_return, ctl_exception_return,
    ctl_nmi_return, ctl_emulation_return, ctl_interrupt_disable, ctl_interrupt_enable
  } control_op_t;

  typedef enum logic [1:0] {
    cache_none, cache_dline_invalidate, cache_dflush, cache_icache_line_flush
  } cache_op_t;

  typedef enum logic [2:0] {
    alu_none, alu_ashr, alu_lshr, alu_lshl, alu_mul, alu_add_shl1, alu_add_shl2,
    alu_divide_step
  } alu_op_t;

  typedef enum logic [1:0] {rel_eq, rel_lt, rel_le} relation_t;
  typedef enum logic [1:0] {opnd_data, opnd_pointer, opnd_accum} operand_t;

  function automatic logic in_range(input logic [15:0] w, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (w >= lo) && (w <= hi);
  endfunction

endpackage

// [design/compare_class_decoder.sv]
`timescale 1ns/100ps
module compare_class_decoder
  import opcode_class_pkg::*;
(
  input wire logic [15:0] insn,
  output logic is_compare,
  output relation_t relation,
  output operand_t operand,
  output logic unsigned_compare_option,
  output logic uses_imm,
  output logic [31:0] imm_value
);

  logic reg_grp;
  logic imm_grp;
  logic [15:0] slot_w;
  logic [3:0] slot;

  always_comb
  begin
    reg_grp = in_range(insn, REG_CMP_LO, REG_CMP_HI);
    imm_grp = in_range(insn, IMM_CMP_LO, IMM_CMP_HI);
    slot_w = imm_grp ? (insn - IMM_CMP_LO) : (insn - REG_CMP_LO);
    slot = slot_w[9:6];
    is_compare = reg_grp || imm_grp;
    uses_imm = imm_grp;
    operand = slot[0] ? opnd_pointer : opnd_data;
    unsigned_compare_option = (slot >= SLOT_LTU);
    if (slot == SLOT_LT || slot == SLOT_LTU || slot == (SLOT_LT + 4'h1)
        || slot == (SLOT_LTU + 4'h1))
      relation = rel_lt;
    else if (slot == SLOT_EQ || slot == (SLOT_EQ + 4'h1))
      relation = rel_eq;
    else
      relation = rel_le;
    // immediates sit in bits 5:3, sign extended unless the compare is unsigned
    if (unsigned_compare_option)
      imm_value = {29'h0, insn[5:3]};
    else
      imm_value = {{29{insn[5]}}, insn[5:3]};
    if (!is_compare)
    begin
      operand = opnd_data;
      relation = rel_eq;
      unsigned_compare_option = 1'b0;
      imm_value = 32'h0;
    end
    // accumulator compares are single codes outside the slot layout
    if (insn == ACC_EQ_CODE || insn == ACC_LT_CODE || insn == ACC_LE_CODE)
    begin
      is_compare = 1'b1;
      operand = opnd_accum;
      unsigned_compare_option = 1'b0;
      imm_value = 32'h0;
      relation = (insn == ACC_EQ_CODE) ? rel_eq : (insn == ACC_LT_CODE) ? rel_lt : rel_le;
    end
  end

endmodule

// [verif/decoder_props.sv]
`timescale 1ns/100ps
module decoder_props
  import opcode_class_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic condition_flag,
  input wire logic decoded_valid,
  input wire op_class_t op_class,
  input wire cache_op_t cache_op,
  input wire alu_op_t alu_op,
  input wire relation_t compare_relation,
  input wire operand_t compare_operand,
  input wire logic unsigned_compare_option,
  input wire logic compare_uses_imm,
  input wire logic condition_flag_write,
  input wire logic jump_on_flag_set,
  input wire logic predicted_taken_hint,
  input wire logic jump_taken,
  input wire logic undefined_insn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_cache_flush_kind: assert property (
    insn_valid && insn_word inside {[16'h0270:16'h027f]} |=>
      op_class == op_cache && cache_op == ($past(insn_word[3]) ? cache_icache_line_flush : cache_dflush))
    else $error("cache flush kind wrong");
  a_ptr_ltu_cmp: assert property (
    insn_valid && insn_word inside {[16'h09c0:16'h09ff]} |=> compare_relation == rel_lt &&
      compare_operand == opnd_pointer && unsigned_compare_option && condition_flag_write)
    else $error("pointer unsigned lt compare wrong");
  a_reg_leu_cmp: assert property (
    insn_valid && insn_word inside {[16'h0a00:16'h0a7f]} |=> compare_relation == rel_le &&
      unsigned_compare_option && condition_flag_write &&
      compare_operand == ($past(insn_word[6]) ? opnd_pointer : opnd_data))
    else $error("unsigned le compare wrong");
  a_accum_cmp: assert property (
    insn_valid && insn_word inside {16'h0a80, 16'h0b00, 16'h0b80} |=>
      compare_operand == opnd_accum && condition_flag_write && compare_relation ==
      (!$past(insn_word[8]) ? rel_eq : ($past(insn_word[7]) ? rel_le : rel_lt)))
    else $error("accumulator compare wrong");
  a_imm_cmp_sign: assert property (
    insn_valid && insn_word inside {[16'h0c00:16'h0e7f]} |=> compare_uses_imm &&
      condition_flag_write && unsigned_compare_option == ($past(insn_word) >= 16'h0d80))
    else $error("immediate compare wrong");
  a_cond_jump_bits: assert property (
    insn_valid && insn_word inside {[16'h1000:16'h1fff]} |=> op_class == op_cond_jump &&
      jump_on_flag_set == $past(insn_word[11]) && predicted_taken_hint == $past(insn_word[10])
      && jump_taken == ($past(condition_flag) == $past(insn_word[11])))
    else $error("conditional jump wrong");
  a_reg_move_range: assert property (
    insn_valid && insn_word[15:12] == 4'h3 |=> op_class == op_reg_move)
    else $error("register move wrong");
  a_alu_kind: assert property (
    insn_valid && insn_word inside {[16'h4000:16'h417f]} |=>
      op_class == op_alu && alu_op == alu_op_t'($past(insn_word[8:6]) + 3'h1))
    else $error("alu kind wrong");
  a_divide_step: assert property (
    insn_valid && insn_word inside {[16'h4200:16'h423f]} |=> alu_op == alu_divide_step)
    else $error("divide step wrong");
  a_undefined_flag: assert property (
    insn_valid && insn_word inside {[16'h0300:16'h07ff], [16'h4180:16'h41ff], 16'hffff} |=>
      undefined_insn && op_class == op_undefined)
    else $error("undefined flag missing");
  a_idle_quiet: assert property (
    !insn_valid |=> !decoded_valid && !undefined_insn)
    else $error("idle slot not quiet");
endmodule

bind short_opcode_class_decoder decoder_props u_props (.sys_clk, .rst_b, .insn_valid,
  .insn_word, .condition_flag, .decoded_valid, .op_class, .cache_op, .alu_op,
  .compare_relation, .compare_operand, .unsigned_compare_option, .compare_uses_imm,
  .condition_flag_write, .jump_on_flag_set, .predicted_taken_hint, .jump_taken,
  .undefined_insn);

// [verif/fetch_model.sv]
`timescale 1ns/100ps
module fetch_model
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic [15:0] req_word,
  input wire logic req_flag,
  output logic insn_valid,
  output logic [15:0] insn_word,
  output logic condition_flag
);
  logic [15:0] last_word;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      last_word <= 16'h0000;
    else if (req)
      last_word <= req_word;
  // an idle fetch bus shows the inverted last word so stale reuse is caught
  assign insn_valid = req;
  assign insn_word = req ? req_word : ~last_word;
  assign condition_flag = req ? req_flag : ~req_flag;
endmodule

// [verif/test_short_opcode_class_decoder.sv]
`timescale 1ns/100ps
module test_short_opcode_class_decoder;
  import opcode_class_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic req_flag = 1'b0;
  logic insn_valid, condition_flag, decoded_valid, unsigned_compare_option, compare_uses_imm;
  logic condition_flag_write, jump_on_flag_set, predicted_taken_hint, jump_taken;
  logic undefined_insn;
  logic [15:0] insn_word;
  op_class_t op_class;
  control_op_t control_op;
  cache_op_t cache_op;
  alu_op_t alu_op;
  relation_t compare_relation;
  operand_t compare_operand;
  logic [31:0] compare_imm;
  logic [12:0] jump_offset;
  logic [2:0] reg_dst, reg_src, move_dst_group, move_src_group;
  int n_mismatch = 0;
  int tests_run = 0;

  initial forever #25 sys_clk = ~sys_clk;

  fetch_model u_fetch (.sys_clk, .rst_b, .req, .req_word, .req_flag, .insn_valid,
    .insn_word, .condition_flag);
  short_opcode_class_decoder dut (.sys_clk, .rst_b, .insn_valid, .insn_word,
    .condition_flag, .decoded_valid, .op_class, .control_op, .cache_op, .alu_op,
    .compare_relation, .compare_operand, .unsigned_compare_option, .compare_uses_imm,
    .compare_imm, .condition_flag_write, .jump_on_flag_set, .predicted_taken_hint,
    .jump_taken, .jump_offset, .reg_dst, .reg_src, .move_dst_group, .move_src_group,
    .undefined_insn);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // the word stays on the bus for a second edge; harmless, the decode repeats
  task automatic apply(input logic [15:0] w, input logic f);
    @(posedge sys_clk);
    req <= 1'b1;
    req_word <= w;
    req_flag <= f;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic t_cache;
    logic [15:0] w [6] = '{16'h0268, 16'h026f, 16'h0270, 16'h0277, 16'h0278, 16'h027f};
    cache_op_t c [3] = '{cache_dline_invalidate, cache_dflush, cache_icache_line_flush};
    for (int i = 0; i < 6; i++)
    begin
      apply(w[i], 1'b0);
      chk("cache_op", 32'(c[i/2]), 32'(cache_op));
      chk("reg_src", 32'(w[i][2:0]), 32'(reg_src));
    end
    $display("cache test done");
  endtask

  task automatic t_reg_cmp;
    logic [15:0] w [9] = '{16'h09c0, 16'h09ff, 16'h0a00, 16'h0a3f, 16'h0a40, 16'h0a7f,
      16'h0a80, 16'h0b00, 16'h0b80};
    relation_t r [9] = '{rel_lt, rel_lt, rel_le, rel_le, rel_le, rel_le, rel_eq, rel_lt, rel_le};
    operand_t o [9] = '{opnd_pointer, opnd_pointer, opnd_data, opnd_data, opnd_pointer,
      opnd_pointer, opnd_accum, opnd_accum, opnd_accum};
    for (int i = 0; i < 9; i++)
    begin
      apply(w[i], 1'b1);
      chk("class", 32'(op_compare), 32'(op_class));
      chk("relation", 32'(r[i]), 32'(compare_relation));
      chk("operand", 32'(o[i]), 32'(compare_operand));
      chk("unsigned", 32'(i < 6), 32'(unsigned_compare_option));
      chk("flag_write", 32'h1, 32'(condition_flag_write));
    end
    $display("register compare test done");
  endtask

  task automatic t_imm_cmp;
    logic [15:0] w [10] = '{16'h0c2b, 16'h0c40, 16'h0cbf, 16'h0cc0, 16'h0d3f, 16'h0d40,
      16'h0da8, 16'h0dff, 16'h0e00, 16'h0e7f};
    relation_t r [5] = '{rel_eq, rel_lt, rel_le, rel_lt, rel_le};
    logic u;
    for (int i = 0; i < 10; i++)
    begin
      u = w[i] >= 16'h0d80;
      apply(w[i], 1'b0);
      chk("relation", 32'(r[i/2]), 32'(compare_relation));
      chk("operand", 32'(w[i][6] ? opnd_pointer : opnd_data),
        32'(compare_operand));
      chk("unsigned", 32'(u), 32'(unsigned_compare_option));
      chk("imm", u ? 32'(w[i][5:3]) : 32'(signed'(w[i][5:3])),
        compare_imm);
      chk("uses_imm", 32'h1, 32'(compare_uses_imm));
    end
    $display("immediate compare test done");
  endtask

  task automatic t_jumps;
    logic [15:0] w [8] = '{16'h1000, 16'h13ff, 16'h1400, 16'h17ff, 16'h1800, 16'h1bff,
      16'h1c05, 16'h1fff};
    for (int i = 0; i < 16; i++)
    begin
      apply(w[i/2], i[0]);
      chk("class", 32'(op_cond_jump), 32'(op_class));
      chk("on_set", 32'(i >= 8), 32'(jump_on_flag_set));
      chk("hint", 32'(i[2]), 32'(predicted_taken_hint));
      chk("taken", 32'(i[0] == (i >= 8)), 32'(jump_taken));
      chk("offset", 32'({{2{w[i/2][9]}}, w[i/2][9:0], 1'b0}),
        32'(jump_offset));
      chk("valid", 32'h1, 32'(decoded_valid));
    end
    // the unconditional short jump is decoded too; make sure it is not a hole
    apply(16'h2abc, 1'b0);
    chk("class", 32'(op_short_jump), 32'(op_class));
    chk("undefined", 32'h0, 32'(undefined_insn));
    chk("taken", 32'h1, 32'(jump_taken));
    chk("offset", 32'h1578, 32'(jump_offset));
    $display("jump test done");
  endtask

  task automatic t_move_alu;
    logic [15:0] w [9] = '{16'h4000, 16'h403f, 16'h4040, 16'h40bf, 16'h40c0, 16'h413f,
      16'h4140, 16'h4200, 16'h423f};
    alu_op_t a [9] = '{alu_ashr, alu_ashr, alu_lshr, alu_lshl, alu_mul, alu_add_shl1,
      alu_add_shl2, alu_divide_step, alu_divide_step};
    apply(16'h3fff, 1'b0);
    chk("class", 32'(op_reg_move), 32'(op_class));
    chk("dst_group", 32'h7, 32'(move_dst_group));
    apply(16'h3000, 1'b0);
    chk("src_group", 32'h0, 32'(move_src_group));
    for (int i = 0; i < 9; i++)
    begin
      apply(w[i], 1'b0);
      chk("alu_op", 32'(a[i]), 32'(alu_op));
      chk("reg_dst", 32'(w[i][2:0]), 32'(reg_dst));
    end
    $display("move and alu test done");
  endtask

  task automatic t_control;
    logic [15:0] w [14] = '{16'h0000, 16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0014,
      16'h0020, 16'h0023, 16'h0024, 16'h0025, 16'h002f, 16'h0033, 16'h0047, 16'h0055};
    control_op_t c [14] = '{ctl_none, ctl_subroutine_return, ctl_interrupt_return,
      ctl_exception_return, ctl_nmi_return, ctl_emulation_return, ctl_idle, ctl_core_sync,
      ctl_system_sync, ctl_emulation_exception, ctl_abort, ctl_interrupt_disable,
      ctl_interrupt_enable, ctl_none};
    op_class_t k [14] = '{op_nop, op_return, op_return, op_return, op_return, op_return,
      op_control, op_control, op_control, op_control, op_control, op_irq_mask, op_irq_mask,
      op_indirect_jump};
    logic [15:0] u [8] = '{16'h0001, 16'h0015, 16'h0300, 16'h0a81, 16'h0b01, 16'h4180,
      16'h4240, 16'hffff};
    for (int i = 0; i < 14; i++)
    begin
      apply(w[i], 1'b0);
      chk("class", 32'(k[i]), 32'(op_class));
      chk("control_op", 32'(c[i]), 32'(control_op));
    end
    chk("reg_src", 32'h5, 32'(reg_src));
    for (int i = 0; i < 8; i++)
    begin
      apply(u[i], 1'b1);
      chk("undefined", 32'h1, 32'(undefined_insn));
      chk("class", 32'(op_undefined), 32'(op_class));
    end
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("idle_valid", 32'h0, 32'(decoded_valid));
    chk("idle_undef", 32'h0, 32'(undefined_insn));
    $display("control and undefined test done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_cache();
    t_reg_cmp();
    t_imm_cmp();
    t_jumps();
    t_move_alu();
    t_control();
    complete_run();
  end
endmodule
